// *** include/pdc_consts.vh ***
// pdc_consts.vh: register offsets, field positions and reset values of the
// port direction control block
// assumes: included by bare name from rtl files
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
// printed offsets are not word multiples: these are register indexes,
// byte address is four times the index
`define PDC_IDX_PORT6    8'hE9
`define PDC_IDX_PORT7    8'hEA
`define PDC_IDX_PORT8    8'hEB
`define PDC_IDX_PORTA    8'hEC
`define PDC_ADDR_LSB     2
`define PDC_ADDR_MSB     9
`define PDC_RST_PORT6    8'h00
`define PDC_RST_PORT7    8'h00
`define PDC_RST_PORT8    8'h00
`define PDC_RST_PORTA    4'h0
`define PDC_PORTA_MSB    3
`define PDC_HTRANS_NSEQ  1
`define PDC_HSIZE_WORD   3'h2
`endif

// *** rtl/pdc_dir_reg.v ***
// pdc_dir_reg.v: one direction register of configurable width
// assumes: write strobe is a one-cycle pulse in the mclk domain
`timescale 1ns/1ns
module pdc_dir_reg #(
  parameter                 WIDTH     = 8,
  parameter [WIDTH-1:0]     RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire               mclk,
  input  wire               resetn,
  input  wire               wrEn,
  input  wire [WIDTH-1:0]   wrData,
  output reg  [WIDTH-1:0]   dirBits
);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dirBits <= RESET_VAL;
    end else if (wrEn) begin
      dirBits <= wrData;
    end
  end
endmodule // pdc_dir_reg

// *** rtl/pdc_port_direction_control.v ***
// pdc_port_direction_control.v: AHB-Lite slave holding pin direction
// registers of ports 6, 7, 8 and A, driving per-pin output enables
// assumes: single master, whole-word single transfers, hready = hreadyout
// assumes: transfers of any other size are ignored and read as zero
// assumes: the pad ring turns each enable bit into that pin's driver enable
//
// Overview of operation
// R1: port 6 direction register, write-only, eight bits, index E9, resets zero.
// R2: port 6 pin is input when its bit is 0, output when 1.
// R3: port 7 direction register, write-only, eight bits, index EA, resets zero.
// R4: port 7 pin is input when its bit is 0, output when 1.
// R5: port 8 direction register, write-only, eight bits, resets zero, 1 means output.
// R6: port A register keeps bits 3..0 read/write; bits 7..4 read as zero.
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_port_direction_control #(
  parameter P6_WIDTH = 8,
  parameter P7_WIDTH = 8,
  parameter P8_WIDTH = 8,
  parameter PA_WIDTH = 4
) (
  input  wire                 mclk,
  input  wire                 resetn,
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output reg  [31:0]          hrdata,
  output reg                  hreadyout,
  output reg                  hresp,
  output reg  [P6_WIDTH-1:0]  port6OutEn,
  output reg  [P7_WIDTH-1:0]  port7OutEn,
  output reg  [P8_WIDTH-1:0]  port8OutEn,
  output reg  [PA_WIDTH-1:0]  portAOutEn
);
  // ----------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------
  reg         dataWrite;
  reg  [7:0]  dataIdx;
  wire        addrValid;
  wire        wordSize;
  wire [7:0]  addrIdx;

  // only whole-word transfers are taken; narrower ones pass as idle
  assign wordSize  = (hsize == `PDC_HSIZE_WORD);
  assign addrValid = hsel & hready & htrans[`PDC_HTRANS_NSEQ] & wordSize;
  assign addrIdx   = haddr[`PDC_ADDR_MSB:`PDC_ADDR_LSB];

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dataWrite <= 1'b0;
      dataIdx   <= 8'h00;
    end else begin
      dataWrite <= addrValid & hwrite;
      // index held over idle cycles; it is only used while dataWrite is set
      if (addrValid) begin
        dataIdx <= addrIdx;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------
  // zero wait states, always OKAY: no register here can refuse a transfer
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  wire [P6_WIDTH-1:0] dir6;
  wire [P7_WIDTH-1:0] dir7;
  wire [P8_WIDTH-1:0] dir8;
  wire [PA_WIDTH-1:0] dirA;

  // one-hot write strobe per register, valid in the data phase of a write
  reg  [3:0]          wrSel;
  always @* begin
    wrSel = 4'h0;
    if (dataWrite) begin
      case (dataIdx)
        // R1 port 6 strobe
        `PDC_IDX_PORT6: begin
          wrSel[0] = 1'b1;
        end
        // R3 port 7 strobe
        `PDC_IDX_PORT7: begin
          wrSel[1] = 1'b1;
        end
        // R5 port 8 strobe
        `PDC_IDX_PORT8: begin
          wrSel[2] = 1'b1;
        end
        // R6 port A strobe
        `PDC_IDX_PORTA: begin
          wrSel[3] = 1'b1;
        end
        // unmapped index: the write is dropped, the bus still answers OKAY
        default: begin
          wrSel = 4'h0;
        end
      endcase
    end
  end

  // R1 port 6 register
  pdc_dir_reg #(.WIDTH(P6_WIDTH), .RESET_VAL(`PDC_RST_PORT6)) u6 (
    .mclk    (mclk),
    .resetn  (resetn),
    .wrEn    (wrSel[0]),
    .wrData  (hwdata[P6_WIDTH-1:0]),
    .dirBits (dir6)
  );
  // R3 port 7 register
  pdc_dir_reg #(.WIDTH(P7_WIDTH), .RESET_VAL(`PDC_RST_PORT7)) u7 (
    .mclk    (mclk),
    .resetn  (resetn),
    .wrEn    (wrSel[1]),
    .wrData  (hwdata[P7_WIDTH-1:0]),
    .dirBits (dir7)
  );
  // R5 port 8 register
  pdc_dir_reg #(.WIDTH(P8_WIDTH), .RESET_VAL(`PDC_RST_PORT8)) u8 (
    .mclk    (mclk),
    .resetn  (resetn),
    .wrEn    (wrSel[2]),
    .wrData  (hwdata[P8_WIDTH-1:0]),
    .dirBits (dir8)
  );
  // R6 port A low nibble
  pdc_dir_reg #(.WIDTH(PA_WIDTH), .RESET_VAL(`PDC_RST_PORTA)) uA (
    .mclk    (mclk),
    .resetn  (resetn),
    .wrEn    (wrSel[3]),
    .wrData  (hwdata[PA_WIDTH-1:0]),
    .dirBits (dirA)
  );

  // ----------------------------------------------------------------
  // pin enables, registered so outputs come from flip-flops
  // ----------------------------------------------------------------
  // one cycle behind the register; reset value keeps every pin an input
  // R2 port 6 select
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port6OutEn <= `PDC_RST_PORT6;
    end else begin
      port6OutEn <= dir6;
    end
  end

  // R4 port 7 select
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port7OutEn <= `PDC_RST_PORT7;
    end else begin
      port7OutEn <= dir7;
    end
  end

  // R5 port 8 select
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port8OutEn <= `PDC_RST_PORT8;
    end else begin
      port8OutEn <= dir8;
    end
  end

  // R6 port A select
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portAOutEn <= `PDC_RST_PORTA;
    end else begin
      portAOutEn <= dirA;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // write-only registers read as zero, so software keeps its own copy of
  // ports 6, 7 and 8; hrdata is loaded at the address phase so it stands
  // during the data phase
  // limitation: a read placed in the data phase of a port A write sees the old value
  reg [31:0] next_hrdata;
  always @* begin
    next_hrdata = 32'h00000000;
    if (addrValid & ~hwrite) begin
      case (addrIdx)
        // R1 R3 R5 write-only reads
        `PDC_IDX_PORT6, `PDC_IDX_PORT7, `PDC_IDX_PORT8: begin
          next_hrdata = 32'h00000000;
        end
        // R6 readback, upper bits zero
        `PDC_IDX_PORTA: begin
          next_hrdata[PA_WIDTH-1:0] = dirA;
        end
        default: begin
          next_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end
endmodule // pdc_port_direction_control

// *** test/pdc_asserts.sv ***
// pdc_asserts.sv: timing checks on the direction control bus slave
// assumes: bound to the top module, hready fed back from hreadyout
`timescale 1ns/1ns
module pdc_asserts (
  input wire        mclk,
  input wire        resetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire [2:0]  hsize,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [7:0]  port6OutEn,
  input wire [7:0]  port7OutEn,
  input wire [7:0]  port8OutEn,
  input wire [3:0]  portAOutEn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire       tk = hsel & hready & htrans[1] & (hsize == 3'h2);
  wire [7:0] ix = haddr[9:2];
  p6_load_a: assert property (tk && hwrite && ix == 8'hE9 |=> ##2
    port6OutEn == $past(hwdata[7:0], 2)) else $error("port 6 enables wrong");
  p7_load_a: assert property (tk && hwrite && ix == 8'hEA |=> ##2
    port7OutEn == $past(hwdata[7:0], 2)) else $error("port 7 enables wrong");
  p8_load_a: assert property (tk && hwrite && ix == 8'hEB |=> ##2
    port8OutEn == $past(hwdata[7:0], 2)) else $error("port 8 enables wrong");
  pa_load_a: assert property (tk && hwrite && ix == 8'hEC |=> ##2
    portAOutEn == $past(hwdata[3:0], 2)) else $error("port A enables wrong");
  wo_read_a: assert property (tk && !hwrite && ix inside {[8'hE9:8'hEB]} |=>
    hrdata == 32'h0) else $error("write-only register read not zero");
  pa_high_a: assert property (tk && !hwrite && ix == 8'hEC |=>
    hrdata[31:4] == 28'h0) else $error("port A high bits not zero");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer wrong");
  cover property (tk && hwrite && ix == 8'hE9);
  cover property (tk && hwrite && ix == 8'hEC);
  cover property (tk && !hwrite && ix == 8'hEC);
endmodule // pdc_asserts
bind pdc_port_direction_control pdc_asserts i_chk (.mclk, .resetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port6OutEn, .port7OutEn,
  .port8OutEn, .portAOutEn);

// *** test/port_direction_control_bench.sv ***
// port_direction_control_bench.sv: random register traffic with read-back
// assumes: zero-wait slave, hready tied to hreadyout
`timescale 1ns/1ns
module port_direction_control_bench;
  logic        mclk = 0, resetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire         hready, hreadyout, hresp;
  wire  [31:0] hrdata;
  wire  [7:0]  port6OutEn, port7OutEn, port8OutEn;
  wire  [3:0]  portAOutEn;
  int          err_total = 0, checks_done = 0;
  integer      seed = 2;
  assign hready = hreadyout;
  pdc_port_direction_control i_dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port6OutEn, .port7OutEn,
    .port8OutEn, .portAOutEn);
  initial forever #5 mclk = ~mclk;
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_pins(input logic [31:0] exp);
    chk({port6OutEn, port7OutEn, port8OutEn, 4'h0, portAOutEn}, exp);
  endtask
  // register index of random slot k; slot 4 is an unmapped index
  function automatic logic [7:0] idx_of(input int k);
    idx_of = (k == 4) ? 8'h10 : 8'hE9 + k[7:0];
  endfunction
  // ports 6, 7, 8 and unmapped read zero; port A returns its low nibble
  function automatic logic [31:0] exp_read(input int k, input logic [31:0] d);
    exp_read = (k == 3) ? {28'h0, d[3:0]} : 32'h0;
  endfunction
  // bounded wait for hready sampled high at a rising edge
  task hwait;
    repeat (50) begin
      @(posedge mclk);
      if (hready === 1'b1) return;
    end
    err_total++;
    conclude;
  endtask
  task bus(input logic w, input logic [7:0] ix, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'h0};
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    q = hrdata;
  endtask
  initial begin
    logic [31:0] q, d;
    logic [7:0]  e [4];
    int          k;
    e = '{8'h0, 8'h0, 8'h0, 8'h0};
    repeat (8) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    chk_pins(32'h0);
    for (int i = 0; i < 30; i++) begin
      k = (i < 4) ? i : $unsigned($random(seed)) % 5;
      d = (i < 4) ? 32'hFFFFFFFF : $random(seed);
      bus(1, idx_of(k), d, q);
      if (k < 4) e[k] = (k == 3) ? {4'h0, d[3:0]} : d[7:0];
      bus(0, idx_of(k), 32'h0, q);
      chk(q, exp_read(k, d));
      chk_pins({e[0], e[1], e[2], e[3]});
    end
    $display("random traffic done");
    resetn <= 0;
    #1 chk_pins(32'h0);
    repeat (3) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    chk_pins(32'h0);
    bus(1, 8'hEC, 32'h0000000A, q);
    bus(0, 8'hEC, 32'h0, q);
    chk(q, exp_read(3, 32'h0000000A));
    chk_pins(32'h0000000A);
    $display("mid-run reset done");
    conclude;
  end
endmodule // port_direction_control_bench
